// ===== rtl/pg_buck_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * power-good and first buck voltage register bank.
 * Assumes a 100 MHz core clock and byte-wide registers behind a serial bus.
 */
`ifndef PG_BUCK_REGS_SVH
`define PG_BUCK_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_UNLOCK       8'h0b
`define ADDR_RAIL_STATUS  8'h0c
`define ADDR_PG_CTRL      8'h0d
`define ADDR_BUCK_CTRL    8'h0e

// ****************************************
// Fields and reset values
// ****************************************
`define PG_MASK_ONE_BIT   3
`define PG_MASK_TWO_BIT   2
`define BUCK_EXT_BIT      7
`define PG_CTRL_RESET     8'h0c
`define BUCK_CTRL_RESET   8'h00
`define UNLOCK_VALUE      8'h7d
`define SYNC_RESET        5'h03
`define DEV_ADDR_DEFAULT  7'h20

// ****************************************
// Timing
// ****************************************
`define MCLK_PERIOD_NS    10
`define MS_NS             1000000
`define PG_DELAY0_MS      9'd20
`define PG_DELAY1_MS      9'd100
`define PG_DELAY2_MS      9'd200
`define PG_DELAY3_MS      9'd400

`endif

// ===== rtl/pg_buck_pkg.sv
/*
 * Types of the power-good and first buck voltage register bank.
 * Assumes nothing beyond the constants header.
 */
package pg_buck_pkg;

    typedef enum logic [3:0] {
        BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_REG, BUS_ACK_REG,
        BUS_WDATA, BUS_ACK_W, BUS_RDATA, BUS_RACK
    } bus_state_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

endpackage

// ===== rtl/power_good_and_buck_voltage_regs.sv
/*
 * Serial-bus slave holding the unlock, rail status, power-good control and
 * first buck voltage control registers, plus the power-good pin logic.
 * Assumes open-drain data line resolved outside; rail status and bus pins
 * are asynchronous to mclk.
 */
`timescale 1ns/1ps
`include "pg_buck_regs.svh"

module power_good_and_buck_voltage_regs
    import pg_buck_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR  = `DEV_ADDR_DEFAULT,
    parameter int          MS_CYCLES = `MS_NS / `MCLK_PERIOD_NS
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        linear_reg_one_good_status,
    input  wire logic        linear_reg_two_good_status,
    input  wire logic        other_rails_good,
    output logic             power_good_output,
    output logic             external_adjust_select,
    output logic [5:0]       first_buck_converter,
    output logic [11:0]      buck_target_mv
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [4:0] s1_q, s2_q, s3_q, flt_q;
    logic       scl_p_q, sda_p_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q  <= `SYNC_RESET;
            s2_q  <= `SYNC_RESET;
            s3_q  <= `SYNC_RESET;
            flt_q <= `SYNC_RESET;
        end else begin
            s1_q  <= {other_rails_good, linear_reg_two_good_status,
                      linear_reg_one_good_status, sda_in, scl_in};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
        end
    end
    logic scl, sda, linear_reg_one_ok, linear_reg_two_ok, rest_ok;
    assign {rest_ok, linear_reg_two_ok, linear_reg_one_ok, sda, scl} = flt_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end
    logic start_c, stop_c, rise_c, fall_c;
    assign start_c = scl & scl_p_q & sda_p_q & ~sda;
    assign stop_c  = scl & scl_p_q & ~sda_p_q & sda;
    assign rise_c  = scl & ~scl_p_q;
    assign fall_c  = ~scl & scl_p_q;

    // ****************************************
    // Register read mux
    // ****************************************
    logic [7:0] unlock_q, pg_q, buck_q, ptr_q;
    logic       armed_q;
    function automatic logic [7:0] rd_val(input logic [7:0] a);
        unique case (a)
            `ADDR_UNLOCK:      rd_val = unlock_q;
            `ADDR_RAIL_STATUS: rd_val = {6'h00, linear_reg_one_ok, linear_reg_two_ok};
            `ADDR_PG_CTRL:     rd_val = pg_q;
            `ADDR_BUCK_CTRL:   rd_val = buck_q;
            default:           rd_val = 8'h00;
        endcase
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    bus_state_t st_q;
    logic [3:0] bitc_q;
    logic [7:0] sh_q, tx_q;
    logic       rd_q, nack_q;
    reg_wr_t    wr_q;
    logic [7:0] rd_now_c, rd_next_c;
    assign sda_out = 1'b0;

    // Read data for the current and the following pointer
    always_comb begin
        rd_now_c  = rd_val(ptr_q);
        rd_next_c = rd_val(ptr_q + 8'h01);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q     <= BUS_IDLE;
            bitc_q   <= 4'h0;
            sh_q     <= 8'h00;
            tx_q     <= 8'h00;
            rd_q     <= 1'b0;
            nack_q   <= 1'b0;
            ptr_q    <= 8'h00;
            sda_oe_n <= 1'b1;
            wr_q     <= '0;
        end else begin
            wr_q.en <= 1'b0;
            if (start_c) begin
                st_q     <= BUS_ADDR;
                bitc_q   <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_c) begin
                st_q     <= BUS_IDLE;
                sda_oe_n <= 1'b1;
            end else if (rise_c) begin
                if (st_q == BUS_RACK) begin
                    nack_q <= sda;
                end else if (st_q != BUS_IDLE && st_q != BUS_ACK_ADDR &&
                             st_q != BUS_ACK_REG && st_q != BUS_ACK_W) begin
                    sh_q   <= {sh_q[6:0], sda};
                    bitc_q <= bitc_q + 4'h1;
                end
            end else if (fall_c) begin
                unique case (st_q)
                    BUS_IDLE: ;
                    BUS_ADDR:
                        if (bitc_q == 4'h8) begin
                            if (sh_q[7:1] == DEV_ADDR) begin
                                st_q     <= BUS_ACK_ADDR;
                                rd_q     <= sh_q[0];
                                sda_oe_n <= 1'b0;
                            end else begin
                                st_q <= BUS_IDLE;
                            end
                        end
                    BUS_ACK_ADDR: begin
                        bitc_q <= 4'h0;
                        if (rd_q) begin
                            st_q     <= BUS_RDATA;
                            tx_q     <= rd_now_c;
                            sda_oe_n <= rd_now_c[7];
                        end else begin
                            st_q     <= BUS_REG;
                            sda_oe_n <= 1'b1;
                        end
                    end
                    BUS_REG:
                        if (bitc_q == 4'h8) begin
                            ptr_q    <= sh_q;
                            st_q     <= BUS_ACK_REG;
                            sda_oe_n <= 1'b0;
                        end
                    BUS_ACK_REG, BUS_ACK_W: begin
                        st_q     <= BUS_WDATA;
                        bitc_q   <= 4'h0;
                        sda_oe_n <= 1'b1;
                    end
                    BUS_WDATA:
                        if (bitc_q == 4'h8) begin
                            wr_q     <= '{en: 1'b1, addr: ptr_q, data: sh_q};
                            ptr_q    <= ptr_q + 8'h01;
                            st_q     <= BUS_ACK_W;
                            sda_oe_n <= 1'b0;
                        end
                    BUS_RDATA:
                        if (bitc_q == 4'h8) begin
                            st_q     <= BUS_RACK;
                            sda_oe_n <= 1'b1;
                        end else begin
                            sda_oe_n <= tx_q[3'(4'h7 - bitc_q)];
                        end
                    BUS_RACK:
                        if (!nack_q) begin
                            ptr_q    <= ptr_q + 8'h01;
                            tx_q     <= rd_next_c;
                            sda_oe_n <= rd_next_c[7];
                            bitc_q   <= 4'h0;
                            st_q     <= BUS_RDATA;
                        end else begin
                            st_q <= BUS_IDLE;
                        end
                endcase
            end
        end
    end

    // ****************************************
    // Unlock and protected registers
    // ****************************************
    logic unlocked_c, prot_hit_c;
    assign unlocked_c = armed_q && (unlock_q == `UNLOCK_VALUE);
    assign prot_hit_c = wr_q.en && (wr_q.addr == `ADDR_PG_CTRL ||
                                    wr_q.addr == `ADDR_BUCK_CTRL);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            unlock_q <= 8'h00;
            armed_q  <= 1'b0;
        end else if (wr_q.en && wr_q.addr == `ADDR_UNLOCK) begin
            unlock_q <= wr_q.data;
            armed_q  <= 1'b0;
        end else if (prot_hit_c || (stop_c && armed_q)) begin
            unlock_q <= 8'h00;
            armed_q  <= 1'b0;
        end else if (stop_c && unlock_q != 8'h00) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pg_q   <= `PG_CTRL_RESET;
            buck_q <= `BUCK_CTRL_RESET;
        end else if (prot_hit_c && unlocked_c) begin
            if (wr_q.addr == `ADDR_PG_CTRL)
                pg_q <= {4'h0, wr_q.data[3:0]};
            else
                buck_q <= {wr_q.data[7], 1'b0, wr_q.data[5:0]};
        end
    end

    // ****************************************
    // Buck voltage target
    // ****************************************
    logic [5:0] code;
    assign code = buck_q[5:0];
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            external_adjust_select <= 1'b0;
            first_buck_converter   <= 6'h00;
            buck_target_mv         <= 12'h000;
        end else begin
            external_adjust_select <= buck_q[`BUCK_EXT_BIT];
            first_buck_converter   <= code;
            if (buck_q[`BUCK_EXT_BIT])
                buck_target_mv <= 12'h000;
            else if (code <= 6'h18)
                buck_target_mv <= 12'd900 + 12'(code) * 12'd25;
            else if (code <= 6'h34)
                buck_target_mv <= 12'd1500 + 12'(code - 6'h18) * 12'd50;
            else if (code <= 6'h37)
                buck_target_mv <= 12'd3000 + 12'(code - 6'h35) * 12'd100;
            else
                buck_target_mv <= 12'd3300;
        end
    end

    // ****************************************
    // Power-good pin
    // ****************************************
    logic       rails_ok_c, ms_tick_q;
    logic [16:0] div_q;
    logic [8:0] ms_q, dly_c;
    assign rails_ok_c = rest_ok
                      && (pg_q[`PG_MASK_ONE_BIT] || linear_reg_one_ok)
                      && (pg_q[`PG_MASK_TWO_BIT] || linear_reg_two_ok);
    always_comb begin
        unique case (pg_q[1:0])
            2'h0: dly_c = `PG_DELAY0_MS;
            2'h1: dly_c = `PG_DELAY1_MS;
            2'h2: dly_c = `PG_DELAY2_MS;
            2'h3: dly_c = `PG_DELAY3_MS;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_q     <= 17'h0;
            ms_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= (div_q == 17'(MS_CYCLES - 1));
            div_q     <= (div_q == 17'(MS_CYCLES - 1)) ? 17'h0 : div_q + 17'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ms_q              <= 9'h0;
            power_good_output <= 1'b0;
        end else if (!rails_ok_c) begin
            ms_q              <= 9'h0;
            power_good_output <= 1'b0;
        end else if (!power_good_output && ms_tick_q) begin
            ms_q <= ms_q + 9'h1;
            if (ms_q + 9'h1 >= dly_c)
                power_good_output <= 1'b1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    pg_reserved_a: assert property (pg_q[7:4] == 4'h0 && buck_q[6] == 1'b0)
        else $error("reserved bits not zero");
    locked_write_a: assert property (prot_hit_c && !unlocked_c |=> $stable(pg_q) && $stable(buck_q))
        else $error("locked register changed");
    unlock_once_a: assert property (prot_hit_c |=> unlock_q == 8'h00 && !armed_q)
        else $error("unlock not consumed");
    mask_one_a: assert property (!pg_q[3] && !linear_reg_one_ok |=> !power_good_output)
        else $error("regulator one not gating");
    mask_two_a: assert property (!pg_q[2] && !linear_reg_two_ok |=> !power_good_output)
        else $error("regulator two not gating");
    pg_release_a: assert property ($rose(power_good_output) |-> $past(ms_q) + 9'h1 >= $past(dly_c))
        else $error("early release");
    pg_drop_a: assert property (!rails_ok_c |=> !power_good_output && ms_q == 9'h0)
        else $error("drop not immediate");
    ext_adjust_a: assert property (buck_q[7] |=> buck_target_mv == 12'h000)
        else $error("code governs in external mode");
    code_zero_a: assert property (!buck_q[7] && code == 6'h00 |=> buck_target_mv == 12'd900)
        else $error("code zero not 0.9 V");
    pg_reset_a: assert property ($fell(rst) |-> pg_q == `PG_CTRL_RESET)
        else $error("power-good control reset value wrong");
    c_unlock_c: cover property (prot_hit_c && unlocked_c);
    c_locked_c: cover property (prot_hit_c && !unlocked_c);
    c_release_c: cover property ($rose(power_good_output));
    c_read_c: cover property (st_q == BUS_RDATA);

endmodule // power_good_and_buck_voltage_regs

// ===== test/bus_host_model.sv
/*
 * Host model on the serial register bus: drives the clock and pulls the data line.
 * Assumes the bench resolves the open-drain data line with a pull-up and feeds it back.
 */
`timescale 1ns/1ps

module bus_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h20
) (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ****************************************
    // Bus phases, ten core clocks each
    // ****************************************
    task automatic ph();
        repeat (10) @(posedge mclk);
        #1;
    endtask

    task automatic start();
        sda_pull = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b1;
        ph();
        scl = 1'b0;
        ph();
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b0;
        ph();
    endtask

    // Eight data bits then the acknowledge bit, MSB first
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx);
        logic [8:0] s;
        logic [8:0] r;
        s = {tx, mack};
        for (int i = 8; i >= 0; i--) begin
            sda_pull = !s[i];
            ph();
            scl = 1'b1;
            ph();
            r[i] = sda;
            scl = 1'b0;
            ph();
        end
        rx = r[8:1];
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r);
        xfer(a, 1'b1, r);
        xfer(d, 1'b1, r);
        stop();
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r);
        xfer(a, 1'b1, r);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, r);
        xfer(8'hff, 1'b1, d);
        stop();
    endtask

    // Every protected write is preceded by its own unlock transaction
    task automatic unlocked_write(input logic [7:0] a, input logic [7:0] d);
        write_reg(8'h0b, 8'h7d);
        write_reg(a, d);
    endtask
endmodule // bus_host_model

// ===== test/power_good_and_buck_voltage_regs_bench.sv
/*
 * Self-checking bench of the power-good and first buck voltage register bank.
 * Assumes the host model on the bus and a millisecond of ten core clocks.
 */
`timescale 1ns/1ps
`include "pg_buck_regs.svh"

module power_good_and_buck_voltage_regs_bench;
    logic        mclk, rst, scl, sda_pull, sda_out, sda_oe_n;
    logic        one_ok, two_ok, others, pg, ext;
    logic [5:0]  code;
    logic [11:0] mv;
    int          err_total, tests_run;
    wire logic   sda = !sda_pull && (sda_oe_n || sda_out);

    bus_host_model #(.DEV_ADDR(`DEV_ADDR_DEFAULT)) i_host (.mclk(mclk), .sda(sda), .scl(scl),
        .sda_pull(sda_pull));
    power_good_and_buck_voltage_regs #(.MS_CYCLES(10)) i_dut (.mclk(mclk), .rst(rst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .linear_reg_one_good_status(one_ok), .linear_reg_two_good_status(two_ok),
        .other_rails_good(others), .power_good_output(pg), .external_adjust_select(ext),
        .first_buck_converter(code), .buck_target_mv(mv));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        i_host.read_reg(a, d);
        chk({4'h0, d}, {4'h0, exp}, what);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_lock();
        rchk(`ADDR_PG_CTRL, 8'h0c, "pg reset");
        i_host.write_reg(`ADDR_PG_CTRL, 8'h01);
        rchk(`ADDR_PG_CTRL, 8'h0c, "locked write");
        i_host.write_reg(`ADDR_UNLOCK, 8'h7c);
        i_host.write_reg(`ADDR_PG_CTRL, 8'h01);
        rchk(`ADDR_PG_CTRL, 8'h0c, "wrong code");
        i_host.unlocked_write(`ADDR_PG_CTRL, 8'hf5);
        rchk(`ADDR_PG_CTRL, 8'h05, "reserved bits");
        rchk(`ADDR_UNLOCK, 8'h00, "unlock cleared");
        i_host.write_reg(`ADDR_PG_CTRL, 8'h0c);
        rchk(`ADDR_PG_CTRL, 8'h05, "single write");
    endtask

    task automatic t_buck();
        logic [7:0]  c [9] = '{8'h00, 8'h01, 8'h18, 8'h19, 8'h34, 8'h35, 8'h37, 8'h38, 8'h3f};
        logic [11:0] v [9] = '{12'h384, 12'h39d, 12'h5dc, 12'h60e, 12'hb54, 12'hbb8, 12'hc80,
                               12'hce4, 12'hce4};
        for (int i = 0; i < 9; i++) begin
            i_host.unlocked_write(`ADDR_BUCK_CTRL, c[i]);
            chk({6'h0, code}, {4'h0, c[i]}, "buck code");
            chk(mv, v[i], "buck voltage");
        end
        i_host.unlocked_write(`ADDR_BUCK_CTRL, 8'hd8);
        chk({11'h0, ext}, 12'h001, "external select");
        chk(mv, 12'h000, "external voltage");
        rchk(`ADDR_BUCK_CTRL, 8'h98, "buck readback");
    endtask

    task automatic t_delay();
        int ms [4] = '{20, 100, 200, 400};
        int n;
        for (int c = 0; c < 4; c++) begin
            i_host.unlocked_write(`ADDR_PG_CTRL, 8'h0c | c[7:0]);
            others = 1'b0;
            tick(8);
            chk({11'h0, pg}, 12'h000, "pin drop");
            others = 1'b1;
            n = 0;
            while (pg !== 1'b1 && n < 5000) begin
                tick(1);
                n++;
            end
            chk({11'h0, n >= (ms[c] - 1) * 10 && n <= ms[c] * 10 + 15}, 12'h001, "delay");
        end
    endtask

    task automatic t_mask();
        one_ok = 1'b0;
        two_ok = 1'b0;
        tick(20);
        chk({11'h0, pg}, 12'h001, "masked rails");
        rchk(`ADDR_RAIL_STATUS, 8'h00, "status off");
        one_ok = 1'b1;
        rchk(`ADDR_RAIL_STATUS, 8'h02, "status one");
        two_ok = 1'b1;
        i_host.unlocked_write(`ADDR_PG_CTRL, 8'h04);
        one_ok = 1'b0;
        tick(6);
        chk({11'h0, pg}, 12'h000, "rail one unmasked");
        one_ok = 1'b1;
        tick(230);
        i_host.unlocked_write(`ADDR_PG_CTRL, 8'h08);
        two_ok = 1'b0;
        tick(6);
        chk({11'h0, pg}, 12'h000, "rail two unmasked");
        two_ok = 1'b1;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (90000) @(posedge mclk);
        err_total++;
        $display("unexpected at %0t: run too long", $time);
        results();
    end

    initial begin
        rst    = 1'b1;
        one_ok = 1'b1;
        two_ok = 1'b1;
        others = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(6);
        chk(mv, 12'h384, "buck reset voltage");
        chk({11'h0, sda_out}, 12'h000, "open-drain data level");
        t_lock();
        t_buck();
        t_delay();
        t_mask();
        results();
    end
endmodule // power_good_and_buck_voltage_regs_bench
